// *** logic/acs_sequencer.sv ***
// Conversion sequencer with classic Wishbone register slave
`timescale 1ns/1ps
`include "acs_regs.svh"

module acs_sequencer #(
  parameter int UNITS12 = `ACS_UNITS12,
  parameter int UNITS8  = `ACS_UNITS8
) (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst,
  // Wishbone slave
  input  wire logic        wb_cyc,
  input  wire logic        wb_stb,
  input  wire logic        wb_we,
  input  wire logic [17:0] wb_adr,
  input  wire logic [3:0]  wb_sel,
  input  wire logic [31:0] wb_dat_w,
  output logic      [31:0] wb_dat_r,
  output logic             wb_ack,
  // Converter core
  input  wire logic [11:0] sar_result,
  output logic             conv_active,
  output logic [4:0]       channel_select,
  // Port pins and interrupt
  output logic [7:0]       port2_digital_inhibit,
  output logic             conv_irq
);
  import acs_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  acs_state_e state_r;
  acs_cnt_t   cnt_r;
  logic [7:0] ctrl_r;
  logic [7:0] mode_r;
  logic [7:0] low_r;
  logic [7:0] high_r;
  logic [7:0] port2_digital_inhibit_r;
  logic [7:0] drv_r;
  logic       first12_r;
  logic       is8_r;
  logic       ack_r;
  logic [7:0] dat_r;

  // Conversion length in clock cycles
  function automatic acs_cnt_t conv_len(input logic [2:0] sel, input logic is8, input logic dbl);
    acs_cnt_t u;
    u = is8 ? acs_cnt_t'(UNITS8) : acs_cnt_t'(UNITS12);
    u = (u << sel) << dbl;
    return acs_cnt_t'((u + acs_cnt_t'(`ACS_UNITS_FIX)) * acs_cnt_t'(`ACS_UNIT_CYC));
  endfunction

  // Register index match
  function automatic logic hit(input logic [17:0] adr, input logic [15:0] idx);
    return adr[17:2] == idx;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode
  logic       req;
  logic       wr;
  logic [7:0] wd;
  logic       wr_ctrl;
  logic       wr_mode;
  logic       wr_low;
  logic       wr_high;
  logic       wr_p2;
  logic       wr_drv;
  logic [2:0] tsel;
  logic [4:0] chan;
  logic [4:0] new_chan;
  logic       start;
  logic       done_evt;
  logic       abort;

  // A request needs cycle and strobe; lane 0 carries every register
  assign req      = wb_cyc & wb_stb;
  assign wr       = req & wb_we & ack_r & wb_sel[0];  // Write lands at the acking edge
  assign wd       = wb_dat_w[7:0];
  assign wr_ctrl  = wr & hit(wb_adr, `ACS_IDX_CTRL);
  assign wr_mode  = wr & hit(wb_adr, `ACS_IDX_MODE);
  assign wr_low   = wr & hit(wb_adr, `ACS_IDX_LOW);
  assign wr_high  = wr & hit(wb_adr, `ACS_IDX_HIGH);
  assign wr_p2    = wr & hit(wb_adr, `ACS_IDX_PORT2_DIGITAL_INHIBIT);
  assign wr_drv   = wr & hit(wb_adr, `ACS_IDX_DRV);

  // Divider select split over two registers
  assign tsel = {low_r[`ACS_LOW_TSEL], mode_r[1:0]};
  assign chan = {drv_r[`ACS_DRV_CHMSB], ctrl_r[`ACS_CTRL_CH_HI:`ACS_CTRL_CH_LO]};
  // A start is judged on the channel code being written, not the stale one
  assign new_chan = {drv_r[`ACS_DRV_CHMSB], wd[`ACS_CTRL_CH_HI:`ACS_CTRL_CH_LO]};

  // Sequencing events
  assign done_evt = (state_r == ACS_CONV) && (cnt_r == acs_cnt_t'(1));
  assign start    = (state_r == ACS_IDLE) && wr_ctrl && wd[`ACS_CTRL_RUN]
                    && (new_chan < `ACS_CH_LIMIT);
  // Abort only while converting; an end in the same cycle wins
  assign abort    = (state_r == ACS_CONV) && wr_ctrl && !wd[`ACS_CTRL_RUN] && !done_evt;

  ////////////////////////////////////////////////////////////////////////////
  // Bus handshake and read data
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ack_r <= 1'b0;
      dat_r <= `ACS_RST_BYTE;
    end else begin
      ack_r <= req & ~ack_r;
      if (req & ~ack_r) begin
        if (hit(wb_adr, `ACS_IDX_CTRL))       dat_r <= ctrl_r;
        else if (hit(wb_adr, `ACS_IDX_MODE))  dat_r <= mode_r;
        else if (hit(wb_adr, `ACS_IDX_LOW))   dat_r <= low_r;
        else if (hit(wb_adr, `ACS_IDX_HIGH))  dat_r <= high_r;
        else if (hit(wb_adr, `ACS_IDX_PORT2_DIGITAL_INHIBIT)) dat_r <= port2_digital_inhibit_r;
        else if (hit(wb_adr, `ACS_IDX_DRV))   dat_r <= drv_r;
        else                                  dat_r <= `ACS_RST_BYTE;
      end
    end
  end

  assign wb_ack   = ack_r;
  assign wb_dat_r = {24'h000000, dat_r};

  ////////////////////////////////////////////////////////////////////////////
  // Conversion state and cycle counter
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_r <= ACS_IDLE;
      cnt_r   <= acs_cnt_t'(0);
      is8_r   <= 1'b0;
    end else begin
      case (state_r)
        ACS_IDLE: begin
          if (start) begin
            state_r <= ACS_CONV;
            is8_r   <= mode_r[`ACS_MODE_RES];
            cnt_r   <= conv_len(tsel, mode_r[`ACS_MODE_RES],
                                first12_r & ~mode_r[`ACS_MODE_RES]);
          end
        end
        ACS_CONV: begin
          cnt_r <= cnt_r - acs_cnt_t'(1);
          if (done_evt || abort) begin
            state_r <= ACS_IDLE;
          end
        end
        default: state_r <= ACS_IDLE;
      endcase
    end
  end

  // First twelve-bit conversion pending after reset or an 8-to-12 switch
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      first12_r <= 1'b1;
    end else if (wr_mode && mode_r[`ACS_MODE_RES] && !wd[`ACS_MODE_RES]) begin
      first12_r <= 1'b1;
    end else if (done_evt && !is8_r) begin
      first12_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control register: run bit follows the state, done flag set wins
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ctrl_r <= `ACS_RST_BYTE;
    end else begin
      if (wr_ctrl) begin
        ctrl_r[7:3]           <= wd[7:3];
        ctrl_r[`ACS_CTRL_IE]  <= wd[`ACS_CTRL_IE];
        ctrl_r[`ACS_CTRL_RUN] <= start | ((state_r == ACS_CONV) & wd[`ACS_CTRL_RUN] & ~done_evt);
      end else if (done_evt) begin
        ctrl_r[`ACS_CTRL_RUN] <= 1'b0;
      end
      if (done_evt) begin
        ctrl_r[`ACS_CTRL_DONE] <= 1'b1;
      end else if (wr_ctrl) begin
        ctrl_r[`ACS_CTRL_DONE] <= wd[`ACS_CTRL_DONE];
      end
    end
  end

  // Mode, port-2 inhibit and driver control registers
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      mode_r  <= `ACS_RST_BYTE;
      port2_digital_inhibit_r <= `ACS_RST_BYTE;
      drv_r   <= `ACS_RST_BYTE;
    end else begin
      if (wr_mode) mode_r <= wd;
      if (wr_p2)   port2_digital_inhibit_r <= wd;
      if (wr_drv)  drv_r <= wd;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Result registers: end of conversion wins over a software write
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      low_r  <= `ACS_RST_BYTE;
      high_r <= `ACS_RST_BYTE;
    end else begin
      // Bits 3..0 belong to software alone
      if (wr_low) low_r[3:0] <= wd[3:0];
      if (done_evt && !is8_r) begin
        low_r[7:4] <= sar_result[3:0];
      end else if (wr_low) begin
        low_r[7:4] <= wd[7:4];
      end
      if (done_evt) begin
        high_r <= is8_r ? sar_result[7:0] : sar_result[11:4];
      end else if (wr_high) begin
        high_r <= wd;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs to the core, pins and interrupt controller
  assign conv_active           = ctrl_r[`ACS_CTRL_RUN];
  assign channel_select        = chan;
  assign port2_digital_inhibit = port2_digital_inhibit_r;
  assign conv_irq              = ctrl_r[`ACS_CTRL_DONE] & ctrl_r[`ACS_CTRL_IE];

  ////////////////////////////////////////////////////////////////////////////
  // Checking helpers: elapsed cycles and independently computed length
  acs_cnt_t el_r;
  acs_cnt_t exp_r;
  logic     dbl_seen_r;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      el_r       <= acs_cnt_t'(0);
      exp_r      <= acs_cnt_t'(0);
      dbl_seen_r <= 1'b0;
    end else if (start) begin
      el_r       <= acs_cnt_t'(0);
      dbl_seen_r <= first12_r & ~mode_r[`ACS_MODE_RES];
      exp_r      <= acs_cnt_t'((((mode_r[`ACS_MODE_RES] ? UNITS8 : UNITS12) << tsel)
                    * ((first12_r & ~mode_r[`ACS_MODE_RES]) ? 2 : 1) + `ACS_UNITS_FIX) * `ACS_UNIT_CYC);
    end else if (state_r == ACS_CONV) begin
      el_r <= el_r + acs_cnt_t'(1);
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  chk_conv_time: assert property (done_evt |-> el_r + acs_cnt_t'(1) == exp_r)
    else $error("Conversion length wrong");
  chk_end_flags: assert property (done_evt |=> ctrl_r[`ACS_CTRL_DONE] && !conv_active && state_r == ACS_IDLE)
    else $error("End did not set done and clear run");
  chk_irq_raise: assert property (done_evt && ctrl_r[`ACS_CTRL_IE] && !wr_ctrl |=> conv_irq)
    else $error("Interrupt not raised at end");
  chk_abort_stop: assert property (abort |=> state_r == ACS_IDLE && !conv_active ##1 !$rose(ctrl_r[`ACS_CTRL_DONE]))
    else $error("Abort did not stop conversion");
  chk_start_run: assert property (start |=> conv_active && state_r == ACS_CONV)
    else $error("Start not taken");
  chk_high_res: assert property (done_evt |=> high_r == ($past(is8_r) ? $past(sar_result[7:0])
                                                                         : $past(sar_result[11:4])))
    else $error("High result wrong");
  chk_low_nibble: assert property (done_evt && !is8_r |=> low_r[7:4] == $past(sar_result[3:0]))
    else $error("Low nibble wrong");
  chk_low_keep: assert property (done_evt && is8_r && !wr_low |=> $stable(low_r))
    else $error("Eight-bit end disturbed low register");
  chk_tsel_keep: assert property (done_evt && !wr_low |=> $stable(low_r[`ACS_LOW_TSEL]))
    else $error("Time select disturbed by result");
  chk_inhibit_out: assert property (wr_p2 |=> port2_digital_inhibit == $past(wd))
    else $error("Inhibit pins not updated");
  chk_bad_chan: assert property (wr_ctrl && state_r == ACS_IDLE && new_chan >= `ACS_CH_LIMIT |=> !conv_active)
    else $error("Illegal channel started");

  cov_end12: cover property (done_evt && !is8_r);
  cov_end8: cover property (done_evt && is8_r);
  cov_double: cover property (done_evt && dbl_seen_r);
  cov_abort: cover property (abort);
  cov_refused: cover property (wr_ctrl && wd[`ACS_CTRL_RUN] && state_r == ACS_IDLE && new_chan >= `ACS_CH_LIMIT);

endmodule

// *** logic/acs_regs.svh ***
// Register indices, field positions, reset values and timing for the conversion sequencer
`ifndef ACS_REGS_SVH
`define ACS_REGS_SVH

// Register indices; byte address is four times the index
`define ACS_IDX_CTRL    16'hfe58
`define ACS_IDX_MODE    16'hfe59
`define ACS_IDX_LOW     16'hfe5a
`define ACS_IDX_HIGH    16'hfe5b
`define ACS_IDX_PORT2_DIGITAL_INHIBIT   16'hfe67
`define ACS_IDX_DRV     16'hfeff

// Reset value of every register
`define ACS_RST_BYTE    8'h00

// Field positions
`define ACS_CTRL_RUN    2
`define ACS_CTRL_DONE   1
`define ACS_CTRL_IE     0
`define ACS_MODE_RES    6
`define ACS_LOW_TSEL    0
`define ACS_DRV_CHMSB   7
`define ACS_CTRL_CH_HI  7
`define ACS_CTRL_CH_LO  4

// Channel codes from this value upward are illegal
`define ACS_CH_LIMIT    5'h14

// Timing: base units of one third of an instruction cycle
`define ACS_CLK_NS      100
`define ACS_THIRD_NS    100
`define ACS_UNIT_CYC    ((`ACS_THIRD_NS + `ACS_CLK_NS - 1) / `ACS_CLK_NS)
`define ACS_UNITS12     52
`define ACS_UNITS8      32
`define ACS_UNITS_FIX   2

`endif

// *** logic/acs_pkg.sv ***
// Types shared by the conversion sequencer
package acs_pkg;
  typedef enum logic {ACS_IDLE, ACS_CONV} acs_state_e;
  typedef logic [15:0] acs_cnt_t;
endpackage

// *** tb/acs_analog_src.sv ***
// Analog source model that feeds the converter core result
`timescale 1ns/1ps
module acs_analog_src (
  // Clock
  input  wire logic        clock,
  // Converter side
  input  wire logic        conv_active,
  input  wire logic [4:0]  channel_select,
  input  wire logic [11:0] level,
  // Result towards the sequencer
  output logic      [11:0] sar_result
);
  // Settled value only while converting; outside that the line shows the inverse
  always @(posedge clock) begin
    if (conv_active) begin
      sar_result <= level ^ {7'h00, channel_select};
    end else begin
      sar_result <= ~(level ^ {7'h00, channel_select});
    end
  end
endmodule

// *** tb/acs_sequencer_test.sv ***
// Self-checking bench for the conversion sequencer
`timescale 1ns/1ps
`include "acs_regs.svh"
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin n_mismatch++; \
  $display("mismatch %s exp %h got %h", nm, e, g); end end
module acs_sequencer_test;
  import acs_pkg::*;
  localparam int U12 = 3;
  localparam int U8  = 2;
  logic        clock = 0, rst = 1, wb_cyc = 0, wb_stb = 0, wb_we = 0, wb_ack, conv_active, conv_irq;
  logic [17:0] wb_adr = 0;
  logic [3:0]  wb_sel = 0;
  logic [31:0] wb_dat_w = 0, wb_dat_r, tmp, seed = 32'hcc44;
  logic [11:0] sar_result, level = 0;
  logic [4:0]  channel_select;
  logic [7:0]  port2_digital_inhibit, q, m_low = 0, m_high = 0;
  bit          first12 = 1, res8_prev = 0;
  int          n_mismatch = 0, compares = 0, cycles = 0;
  logic [15:0] seen_q [$], exp_q [$];
  logic [15:0] idxs [6] = '{`ACS_IDX_CTRL, `ACS_IDX_MODE, `ACS_IDX_LOW, `ACS_IDX_HIGH, `ACS_IDX_PORT2_DIGITAL_INHIBIT, `ACS_IDX_DRV};

  // Clock
  always #50 clock = ~clock;

  acs_sequencer #(.UNITS12(U12), .UNITS8(U8)) dut_u (.clock(clock), .rst(rst), .wb_cyc(wb_cyc),
    .wb_stb(wb_stb), .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel), .wb_dat_w(wb_dat_w),
    .wb_dat_r(wb_dat_r), .wb_ack(wb_ack), .sar_result(sar_result), .conv_active(conv_active),
    .channel_select(channel_select), .port2_digital_inhibit(port2_digital_inhibit), .conv_irq(conv_irq));
  acs_analog_src src_u (.clock(clock), .conv_active(conv_active), .channel_select(channel_select),
    .level(level), .sar_result(sar_result));

  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Trimmed mean: drop the largest and smallest, average the rest
  function automatic logic [15:0] trim_avg(input logic [15:0] v [$]);
    logic [15:0] s, lo, hi;
    s = 16'h0000;
    lo = v[0];
    hi = v[0];
    foreach (v[k]) begin
      s = s + v[k];
      if (v[k] < lo) lo = v[k];
      if (v[k] > hi) hi = v[k];
    end
    return (s - lo - hi) / 16'(v.size() - 2);
  endfunction

  // One classic Wishbone cycle; held until ack is sampled high
  task wb(input logic we, input logic [15:0] idx, input logic [7:0] d);
    @(posedge clock);
    wb_cyc <= 1; wb_stb <= 1; wb_we <= we; wb_adr <= {idx, 2'b00}; wb_sel <= 4'h1; wb_dat_w <= {24'h0, d};
    do @(posedge clock); while (wb_ack !== 1'b1);
    q = wb_dat_r[7:0];
    wb_cyc <= 0; wb_stb <= 0;
  endtask

  task chk_reg(input string nm, input logic [15:0] idx, input logic [7:0] e);
    wb(0, idx, 8'h00);
    `CHK(nm, e, q)
  endtask

  // Resolution and divider select; a 1 to 0 step of resolution re-arms doubling
  task set_mode(input bit r8, input logic [2:0] sel);
    if (!r8 && res8_prev) first12 = 1;
    res8_prev = r8;
    wb(1, `ACS_IDX_MODE, {1'b0, r8, 4'h0, sel[1:0]});
    m_low = {m_low[7:4], 3'b000, sel[2]};
    wb(1, `ACS_IDX_LOW, m_low);
  endtask

  // Full conversion: start, time it, poll, read results, clear the flag
  task conv(input bit r8, input logic [2:0] sel, input bit ie);
    int n, len;
    logic [4:0] ch;
    logic [11:0] res;
    tmp = rnd();
    ch = 5'(tmp[15:0] % 20);
    set_mode(r8, sel);
    wb(1, `ACS_IDX_DRV, {ch[4], 7'h00});
    level <= tmp[27:16];
    res = tmp[27:16] ^ {7'h00, ch};
    wb(1, `ACS_IDX_CTRL, {ch[3:0], 3'b010, ie});
    len = ((r8 ? U8 : U12) << sel) * ((!r8 && first12) ? 2 : 1) + 2;
    n = 0;
    do begin @(posedge clock); if (conv_active === 1'b1) n++; end while (conv_active === 1'b1);
    `CHK("length", len, n)
    `CHK("channel", ch, channel_select)
    `CHK("irq", ie, conv_irq)
    if (!r8) begin first12 = 0; m_low[7:4] = res[3:0]; end
    m_high = r8 ? res[7:0] : res[11:4];
    chk_reg("ctrl", `ACS_IDX_CTRL, {ch[3:0], 3'b001, ie});
    chk_reg("high", `ACS_IDX_HIGH, m_high);
    seen_q.push_back(16'(q));
    exp_q.push_back(16'(m_high));
    chk_reg("low", `ACS_IDX_LOW, m_low);
    wb(1, `ACS_IDX_CTRL, {ch[3:0], 4'b0001});
    @(posedge clock);
    `CHK("irq clear", 1'b0, conv_irq)
    $display("test conversion res8 %0d sel %0d done", r8, sel);
  endtask

  task results();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // Hang guard
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin n_mismatch++; results(); end
  end

  // Main sequence
  initial begin
    repeat (2) @(posedge clock);
    rst <= 0;
    foreach (idxs[k]) chk_reg("reset", idxs[k], 8'h00);
    wb(1, 16'hfe70, 8'hff);
    chk_reg("unmapped", 16'hfe70, 8'h00);
    tmp = rnd();
    wb(1, `ACS_IDX_PORT2_DIGITAL_INHIBIT, tmp[7:0]);
    chk_reg("inhibit", `ACS_IDX_PORT2_DIGITAL_INHIBIT, tmp[7:0]);
    `CHK("inhibit pins", tmp[7:0], port2_digital_inhibit)
    $display("test registers done");
    conv(0, 3'd0, 1);
    conv(0, 3'd1, 1);
    for (int i = 0; i < 8; i++) conv(i[0], i[2:0], i[1]);
    `CHK("trimmed mean", trim_avg(exp_q), trim_avg(seen_q))
    $display("test trimmed mean done");
    // Abort in mid-conversion leaves flag and results alone
    set_mode(0, 3'd0);
    wb(1, `ACS_IDX_DRV, 8'h00);
    wb(1, `ACS_IDX_CTRL, 8'h04);
    wb(1, `ACS_IDX_CTRL, 8'h00);
    @(posedge clock);
    `CHK("abort active", 1'b0, conv_active)
    chk_reg("abort ctrl", `ACS_IDX_CTRL, 8'h00);
    chk_reg("abort high", `ACS_IDX_HIGH, m_high);
    // Illegal channel code refuses the start
    wb(1, `ACS_IDX_DRV, 8'h80);
    wb(1, `ACS_IDX_CTRL, 8'h44);
    @(posedge clock);
    `CHK("illegal active", 1'b0, conv_active)
    chk_reg("illegal ctrl", `ACS_IDX_CTRL, 8'h40);
    $display("test abort and refusal done");
    // Reset during a conversion
    wb(1, `ACS_IDX_DRV, 8'h00);
    wb(1, `ACS_IDX_CTRL, 8'h04);
    rst <= 1;
    repeat (2) @(posedge clock);
    `CHK("reset active", 1'b0, conv_active)
    rst <= 0;
    first12 = 1; res8_prev = 0; m_low = 0; m_high = 0;
    chk_reg("reset ctrl", `ACS_IDX_CTRL, 8'h00);
    $display("test reset in conversion done");
    conv(0, 3'd2, 0);
    results();
  end
endmodule
